/* hdl/rrn_exec.sv */
// rotate-right-no-carry execution datapath, four phases per instruction
`timescale 1ns/1ns
module rrn_exec (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // instruction request
  input wire logic start_i,
  input wire rrn_pkg::rrn_instr_t instr_i,
  input wire logic ext_set_en_i,
  input wire logic [3:0] bank_select_register_i,
  input wire logic [7:0] fsr2_base_i,
  // register file read port, data valid the cycle after address
  output logic [11:0] rd_addr_o,
  input wire logic [7:0] rd_data_i,
  // status and working register
  input wire logic [7:0] status_i,
  output logic [7:0] status_o,
  output logic status_we_o,
  output logic [7:0] wreg_o,
  output logic wreg_we_o,
  // register file write port
  output rrn_pkg::rrn_wr_t file_wr_o,
  output logic busy_o,
  output logic done_o
);
  ////////////////////////////////////////////////////////////////////////////
  // helper functions
  function automatic logic [7:0] rot_right(input logic [7:0] v);
    rot_right = {v[0], v[7:1]};
  endfunction : rot_right

  // effective address; indexed mode overrides the access bank low window
  function automatic logic [11:0] eff_addr(input rrn_pkg::rrn_instr_t ins,
      input logic ext, input logic [3:0] bank, input logic [7:0] base);
    logic [7:0] sum;
    sum = 8'(base + ins.f_addr);
    if (!ins.access_sel && ext && ins.f_addr <= rrn_pkg::RRN_IDX_LIMIT)
      eff_addr = {4'h0, sum};
    else if (!ins.access_sel)
      eff_addr = {(ins.f_addr < rrn_pkg::RRN_ACCESS_SPLIT) ?
                  rrn_pkg::RRN_ACCESS_LO_BANK :
                  rrn_pkg::RRN_ACCESS_HI_BANK, ins.f_addr};
    else
      eff_addr = {bank, ins.f_addr};
  endfunction : eff_addr

  ////////////////////////////////////////////////////////////////////////////
  // state
  rrn_pkg::rrn_phase_t phase_reg, phase_next;
  rrn_pkg::rrn_instr_t ins_reg, ins_next;
  logic [11:0] addr_reg, addr_next;
  logic [7:0] res_reg, res_next;
  logic [7:0] status_reg, status_next;
  logic status_we_reg, status_we_next;
  logic [7:0] wreg_reg, wreg_next;
  logic wreg_we_reg, wreg_we_next;
  rrn_pkg::rrn_wr_t wr_reg, wr_next;
  logic done_reg, done_next;
  logic busy_reg, busy_next;

  // next-state logic: one phase per clock, Q1..Q4 then idle
  always_comb begin
    phase_next = phase_reg;
    ins_next = ins_reg;
    addr_next = addr_reg;
    res_next = res_reg;
    status_next = status_reg;
    status_we_next = 1'b0;
    wreg_next = wreg_reg;
    wreg_we_next = 1'b0;
    wr_next = '{we: 1'b0, addr: addr_reg, data: res_reg};
    done_next = 1'b0;
    case (phase_reg)
      rrn_pkg::RRN_IDLE: begin
        if (start_i) begin
          ins_next = instr_i;
          phase_next = rrn_pkg::RRN_Q1;
        end
      end
      rrn_pkg::RRN_Q1: begin
        // decode: bank and mode sampled now, so later changes are harmless
        addr_next = eff_addr(ins_reg, ext_set_en_i,
                             bank_select_register_i, fsr2_base_i);
        phase_next = rrn_pkg::RRN_Q2;
      end
      rrn_pkg::RRN_Q2: begin
        phase_next = rrn_pkg::RRN_Q3;  // read address is on rd_addr_o
      end
      rrn_pkg::RRN_Q3: begin
        res_next = rot_right(rd_data_i);
        status_next = status_i;
        status_next[rrn_pkg::RRN_STATUS_N] = rd_data_i[0];
        status_next[rrn_pkg::RRN_STATUS_Z] = (rd_data_i == 8'h00);
        phase_next = rrn_pkg::RRN_Q4;
      end
      rrn_pkg::RRN_Q4: begin
        status_we_next = 1'b1;
        if (ins_reg.dest_sel) begin
          wr_next = '{we: 1'b1, addr: addr_reg, data: res_reg};
        end else begin
          wreg_next = res_reg;
          wreg_we_next = 1'b1;
        end
        done_next = 1'b1;
        phase_next = rrn_pkg::RRN_IDLE;
      end
      default: phase_next = rrn_pkg::RRN_IDLE;
    endcase
    // busy follows the next phase so the port comes from a flip-flop
    busy_next = (phase_next != rrn_pkg::RRN_IDLE);
  end

  // registers
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      phase_reg <= rrn_pkg::RRN_IDLE;
      ins_reg <= '0;
      addr_reg <= rrn_pkg::RRN_RESET_ADDR;
      res_reg <= rrn_pkg::RRN_RESET_BYTE;
      status_reg <= rrn_pkg::RRN_RESET_BYTE;
      status_we_reg <= 1'b0;
      wreg_reg <= rrn_pkg::RRN_RESET_BYTE;
      wreg_we_reg <= 1'b0;
      wr_reg <= '0;
      done_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      phase_reg <= phase_next;
      ins_reg <= ins_next;
      addr_reg <= addr_next;
      res_reg <= res_next;
      status_reg <= status_next;
      status_we_reg <= status_we_next;
      wreg_reg <= wreg_next;
      wreg_we_reg <= wreg_we_next;
      wr_reg <= wr_next;
      done_reg <= done_next;
      busy_reg <= busy_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all straight from flip-flops
  assign rd_addr_o = addr_reg;
  assign status_o = status_reg;
  assign status_we_o = status_we_reg;
  assign wreg_o = wreg_reg;
  assign wreg_we_o = wreg_we_reg;
  assign file_wr_o = wr_reg;
  assign done_o = done_reg;
  assign busy_o = busy_reg;

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  a_rotate_result: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    phase_reg == rrn_pkg::RRN_Q3 |=> res_reg == rot_right($past(rd_data_i)))
    else $error("rotated result wrong");
  a_wrap_bit: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    phase_reg == rrn_pkg::RRN_Q3 |=> res_reg[7] == $past(rd_data_i[0]))
    else $error("bit 0 did not wrap to bit 7");
  a_carry_kept: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    phase_reg == rrn_pkg::RRN_Q3 |=>
      {status_reg[7:5], status_reg[3], status_reg[1:0]} ==
      $past({status_i[7:5], status_i[3], status_i[1:0]}))
    else $error("flag other than N or Z changed");
  a_zero_flag: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    status_we_o |-> status_o[rrn_pkg::RRN_STATUS_Z] == (res_reg == 8'h00))
    else $error("zero flag wrong");
  a_dest_wreg: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    done_o |-> (wreg_we_o != file_wr_o.we) &&
      (file_wr_o.we == ins_reg.dest_sel))
    else $error("wrong destination");
  a_bank_used: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    phase_reg == rrn_pkg::RRN_Q1 && ins_reg.access_sel |=>
      rd_addr_o[11:8] == $past(bank_select_register_i))
    else $error("bank select not used");
  a_indexed_addr: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    phase_reg == rrn_pkg::RRN_Q1 && !ins_reg.access_sel && ext_set_en_i &&
      ins_reg.f_addr <= rrn_pkg::RRN_IDX_LIMIT |=>
      rd_addr_o == {4'h0, 8'($past(fsr2_base_i) + $past(ins_reg.f_addr))})
    else $error("indexed address wrong");
  // taken at edge k, phases at k..k+3, done registered at k+4, seen at k+5
  a_four_phases: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    phase_reg == rrn_pkg::RRN_IDLE && start_i |-> ##5 done_o)
    else $error("instruction not done in four phases");

  // flags, writes, addressing and pacing
  a_neg_flag: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    status_we_o |-> status_o[rrn_pkg::RRN_STATUS_N] == res_reg[7])
    else $error("negative flag wrong");
  a_flags_with_done: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    status_we_o == done_o)
    else $error("status write not with done");
  a_wreg_value: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    wreg_we_o |-> wreg_o == res_reg)
    else $error("working register value wrong");
  a_file_value: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    file_wr_o.we |-> file_wr_o.data == res_reg &&
      file_wr_o.addr == rd_addr_o)
    else $error("write back value or address wrong");
  a_access_bank: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    phase_reg == rrn_pkg::RRN_Q1 && !ins_reg.access_sel &&
      !(ext_set_en_i && ins_reg.f_addr <= rrn_pkg::RRN_IDX_LIMIT) |=>
      rd_addr_o[7:0] == $past(ins_reg.f_addr) &&
      rd_addr_o[11:8] == (rd_addr_o[7:0] < rrn_pkg::RRN_ACCESS_SPLIT ?
        rrn_pkg::RRN_ACCESS_LO_BANK : rrn_pkg::RRN_ACCESS_HI_BANK))
    else $error("access bank address wrong");
  a_refused_start: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    phase_reg != rrn_pkg::RRN_IDLE |=> $stable(ins_reg))
    else $error("instruction changed while busy");
  a_done_pulse: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    done_o |=> !done_o)
    else $error("done longer than one cycle");
  a_read_window: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    phase_reg == rrn_pkg::RRN_Q2 |=> $stable(rd_addr_o))
    else $error("read address moved during read");
  a_pulse_idle: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    !done_o |-> !status_we_o && !wreg_we_o && !file_wr_o.we)
    else $error("write pulse outside done");
endmodule : rrn_exec

/* hdl/rrn_pkg.sv */
// package: constants, types and functional notes for the rotate-right datapath
package rrn_pkg;
  localparam logic [7:0] RRN_IDX_LIMIT = 8'h5F;  // last indexed address
  localparam logic [7:0] RRN_ACCESS_SPLIT = 8'h80; // low half: access ram
  localparam logic [3:0] RRN_ACCESS_HI_BANK = 4'hF; // upper access half
  localparam logic [3:0] RRN_ACCESS_LO_BANK = 4'h0;
  localparam int RRN_STATUS_N = 4;  // negative flag position
  localparam int RRN_STATUS_Z = 2;  // zero flag position
  localparam logic [7:0] RRN_RESET_BYTE = 8'h00;
  localparam logic [11:0] RRN_RESET_ADDR = 12'h000;

  typedef enum {RRN_IDLE, RRN_Q1, RRN_Q2, RRN_Q3, RRN_Q4} rrn_phase_t;

  // decoded operand fields of one instruction
  typedef struct packed {
    logic [7:0] f_addr;
    logic dest_sel;
    logic access_sel;
  } rrn_instr_t;

  // register file write request
  typedef struct packed {
    logic we;
    logic [11:0] addr;
    logic [7:0] data;
  } rrn_wr_t;
endpackage : rrn_pkg

/* sim/tb.sv */
// self-checking bench for the rotate-right execution datapath
`timescale 1ns/1ns
module tb;
  typedef struct {
    logic [7:0] f; logic d; logic a; logic ext; logic [3:0] bank_select_register;
    logic [7:0] base; logic [7:0] src; logic [7:0] res; logic [11:0] addr;
  } rrn_row_t;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic start_i = 1'b0;
  rrn_pkg::rrn_instr_t instr_i = '0;
  logic ext_set_en_i = 1'b0;
  logic [3:0] bank_select_register_i = 4'h0;
  logic [7:0] fsr2_base_i = 8'h00;
  logic [7:0] rd_data_i = 8'h00;
  logic [7:0] status_i = 8'h00;
  logic [11:0] rd_addr_o;
  logic [7:0] status_o;
  logic [7:0] wreg_o;
  logic [7:0] exp_st;
  logic status_we_o;
  logic wreg_we_o;
  logic busy_o;
  logic done_o;
  rrn_pkg::rrn_wr_t file_wr_o;
  int num_errors = 0;
  int compares = 0;
  int n;
  int cnt;
  // f, d, a, ext, bank, base, source, result, expected address
  rrn_row_t rows [7] = '{
    '{8'h10, 1'b1, 1'b0, 1'b0, 4'h3, 8'h20, 8'hD7, 8'hEB, 12'h010},
    '{8'h10, 1'b0, 1'b0, 1'b0, 4'h3, 8'h20, 8'hD7, 8'hEB, 12'h010},
    '{8'h90, 1'b1, 1'b0, 1'b0, 4'h3, 8'h20, 8'h01, 8'h80, 12'hF90},
    '{8'h22, 1'b1, 1'b1, 1'b1, 4'h5, 8'h20, 8'h00, 8'h00, 12'h522},
    '{8'h5F, 1'b0, 1'b0, 1'b1, 4'h5, 8'hA0, 8'hFE, 8'h7F, 12'h0FF},
    '{8'h60, 1'b1, 1'b0, 1'b1, 4'h5, 8'hA0, 8'h02, 8'h01, 12'h060},
    '{8'h5F, 1'b1, 1'b0, 1'b1, 4'h5, 8'hC0, 8'h80, 8'h40, 12'h01F}};

  // 10 MHz core clock
  always #50 clk_i = ~clk_i;

  rrn_exec i_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .start_i(start_i),
    .instr_i(instr_i), .ext_set_en_i(ext_set_en_i),
    .bank_select_register_i(bank_select_register_i),
    .fsr2_base_i(fsr2_base_i), .rd_addr_o(rd_addr_o),
    .rd_data_i(rd_data_i), .status_i(status_i), .status_o(status_o),
    .status_we_o(status_we_o), .wreg_o(wreg_o), .wreg_we_o(wreg_we_o),
    .file_wr_o(file_wr_o), .busy_o(busy_o), .done_o(done_o));

  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic print_verdict();
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict

  // one request; waits for done with a bound so a hang ends the run
  task automatic launch(input rrn_row_t r);
    instr_i = '{r.f, r.d, r.a};
    ext_set_en_i = r.ext;
    bank_select_register_i = r.bank_select_register;
    fsr2_base_i = r.base;
    status_i = ~r.src;
    start_i = 1'b1;
    @(posedge clk_i) #10 start_i = 1'b0;
    n = 0;
    // operand stands only in the read cycle, so a late sample shows up
    while (done_o !== 1'b1 && n < 10) begin
      @(posedge clk_i) #10 n++;
      rd_data_i = (n == 2) ? r.src : ~r.src;
    end
    if (n >= 10) begin
      num_errors++;
      print_verdict();
    end
  endtask : launch

  ////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk_i);
    #10 sys_rst_i = 1'b0;
    chk(12'(busy_o), 12'h0);
    foreach (rows[i]) begin
      launch(rows[i]);
      exp_st = ~rows[i].src;
      exp_st[rrn_pkg::RRN_STATUS_N] = rows[i].res[7];
      exp_st[rrn_pkg::RRN_STATUS_Z] = (rows[i].res == 8'h00);
      chk(12'(n), 12'h004);
      chk(rd_addr_o, rows[i].addr);
      chk(12'(status_we_o), 12'h001);
      chk(12'(status_o), 12'(exp_st));
      chk(12'(file_wr_o.we), 12'(rows[i].d));
      chk(12'(wreg_we_o), 12'(!rows[i].d));
      if (rows[i].d) begin
        chk(12'(file_wr_o.data), 12'(rows[i].res));
        chk(file_wr_o.addr, rows[i].addr);
      end else begin
        chk(12'(wreg_o), 12'(rows[i].res));
      end
    end
    // start held high: back to back, requests while busy are dropped
    cnt = 0;
    start_i = 1'b1;
    repeat (10) begin
      @(posedge clk_i) #10 cnt += done_o;
    end
    start_i = 1'b0;
    repeat (6) begin
      @(posedge clk_i) #10 cnt += done_o;
    end
    chk(12'(cnt), 12'h002);
    // reset in mid-operation clears outputs and drops the operation
    launch_abort: begin
      start_i = 1'b1;
      @(posedge clk_i) #10 start_i = 1'b0;
      @(posedge clk_i) #10 sys_rst_i = 1'b1;
      @(posedge clk_i) #10 sys_rst_i = 1'b0;
      chk(12'({busy_o, wreg_we_o, status_we_o, file_wr_o.we}), 12'h0);
      chk(12'(wreg_o), 12'h0);
      cnt = 0;
      repeat (6) begin
        @(posedge clk_i) #10 cnt += done_o;
      end
      chk(12'(cnt), 12'h000);
      // a fresh request after the mid-run reset runs normally
      launch(rows[3]);
      chk(12'(n), 12'h004);
      chk(rd_addr_o, rows[3].addr);
    end
    print_verdict();
  end
endmodule : tb
